// file: core/bsfa_core.sv
// Status and fault flag aggregation with field command port
`timescale 1ns/1ps
//
// Contract
// - Algorithm summary is OR of algorithm detail
// - Detail bit 0 flags init error, hard
// - Detail bit 1 flags fatal range, hard
// - Data summary is OR of data detail
// - Data bit 0 flags calibration checksum fault
// - Hardware summary is OR of masked field
// - Hardware bit 3 shows calibration write unlock
// - Software summary is OR of masked field
// - Software bit 0 shows filter initializing
// - Software bit 2 shows orientation-only tracking
// - Software bit 3 shows turn rate exceeded
// - Sensor summary is OR of masked field
// - Sensor bit 0 shows range excursion
// - Masks accessed only by field read/write
// - Hardware mask 0x0010, link mask 0x0011
// - Software mask 0x0012, sensor mask 0x0013
// - Enabled link condition raises link and alert
// - Masked-off bit never affects any summary
// - Top alert is OR of four summaries
// - Software fault is OR of error group
// - Alert bit 8, summaries bits 9 to 12
// - Hard errors raise top fatal at once
module bsfa_core
  import bsfa_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  // Error sources
  input wire logic init_error,
  input wire logic range_fatal,
  input wire logic calib_checksum_fault,
  // Condition sources
  input wire logic calib_write_unlocked,
  input wire logic filter_initializing,
  input wire logic orientation_only_tracking,
  input wire logic turn_rate_exceeded,
  input wire logic range_excursion,
  input wire logic [FW-1:0] link_condition,
  // Field command port
  input wire logic fld_cmd_valid,
  input wire logic fld_cmd_write,
  input wire logic [FW-1:0] fld_id,
  input wire logic [FW-1:0] fld_wdata,
  output logic fld_rsp_valid,
  output logic fld_rsp_error,
  output logic [FW-1:0] fld_rsp_data,
  // Fields
  output logic [FW-1:0] algorithm_error_detail,
  output logic [FW-1:0] data_error_detail,
  output logic [FW-1:0] sw_error_group,
  output logic [FW-1:0] hw_condition,
  output logic [FW-1:0] sw_condition,
  output logic [FW-1:0] sensor_condition,
  output logic [FW-1:0] health_master_word
);

  logic [FW-1:0] hw_condition_enable_mask;
  logic [FW-1:0] link_condition_enable_mask;
  logic [FW-1:0] sw_condition_enable_mask;
  logic [FW-1:0] sensor_condition_enable_mask;
  logic [FW-1:0] link_field;

  logic [FW-1:0] alg_set;
  logic [FW-1:0] data_set;
  logic [FW-1:0] next_alg;
  logic [FW-1:0] next_data;
  logic [FW-1:0] next_grp;
  logic [FW-1:0] next_hw;
  logic [FW-1:0] next_sw;
  logic [FW-1:0] next_sns;
  logic [FW-1:0] next_link;
  logic [FW-1:0] next_hw_mask;
  logic [FW-1:0] next_link_mask;
  logic [FW-1:0] next_sw_mask;
  logic [FW-1:0] next_sns_mask;
  logic [FW-1:0] next_word;
  logic [FW-1:0] rd_value;
  logic id_hit;
  logic wr_en;
  logic hw_sum;
  logic link_sum;
  logic sw_sum;
  logic sns_sum;

  // ************************************************
  // Hard error detail fields
  // ************************************************

  // Sticky until reset: hard failures are fatal
  always_comb begin
    alg_set = FIELD_RST;
    data_set = FIELD_RST;
    alg_set[ALG_INIT_BIT] = init_error;
    alg_set[ALG_RANGE_BIT] = range_fatal;
    data_set[DATA_CALIB_BIT] = calib_checksum_fault;
    // Reserved bits masked off
    next_alg = (algorithm_error_detail | alg_set) & ALG_VALID;
    next_data = (data_error_detail | data_set) & DATA_VALID;
    next_grp = FIELD_RST;
    next_grp[GRP_ALG_BIT] = |next_alg;
    next_grp[GRP_DATA_BIT] = |next_data;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      algorithm_error_detail <= FIELD_RST;
      data_error_detail <= FIELD_RST;
      sw_error_group <= FIELD_RST;
    end else if (ce) begin
      algorithm_error_detail <= next_alg;
      data_error_detail <= next_data;
      sw_error_group <= next_grp & GRP_VALID;
    end
  end

  // ************************************************
  // Condition fields
  // ************************************************

  always_comb begin
    next_hw = FIELD_RST;
    next_sw = FIELD_RST;
    next_sns = FIELD_RST;
    next_hw[HW_UNLOCK_BIT] = calib_write_unlocked;
    next_sw[SW_INIT_BIT] = filter_initializing;
    next_sw[SW_ORIENT_BIT] = orientation_only_tracking;
    next_sw[SW_TURN_BIT] = turn_rate_exceeded;
    next_sns[SNS_RANGE_BIT] = range_excursion;
    next_link = link_condition & LINK_VALID;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hw_condition <= FIELD_RST;
      sw_condition <= FIELD_RST;
      sensor_condition <= FIELD_RST;
      link_field <= FIELD_RST;
    end else if (ce) begin
      hw_condition <= next_hw;
      sw_condition <= next_sw;
      sensor_condition <= next_sns;
      link_field <= next_link;
    end
  end

  // ************************************************
  // Enable masks and field commands
  // ************************************************

  assign wr_en = fld_cmd_valid && fld_cmd_write;

  // Only the field port reaches the masks
  always_comb begin
    next_hw_mask = hw_condition_enable_mask;
    next_link_mask = link_condition_enable_mask;
    next_sw_mask = sw_condition_enable_mask;
    next_sns_mask = sensor_condition_enable_mask;
    id_hit = 1'b1;
    rd_value = FIELD_RST;
    unique case (fld_id)
      FID_HW_MASK: begin
        rd_value = hw_condition_enable_mask;
        if (wr_en) begin
          next_hw_mask = fld_wdata & HW_VALID;
        end
      end
      FID_LINK_MASK: begin
        rd_value = link_condition_enable_mask;
        if (wr_en) begin
          next_link_mask = fld_wdata & LINK_VALID;
        end
      end
      FID_SW_MASK: begin
        rd_value = sw_condition_enable_mask;
        if (wr_en) begin
          next_sw_mask = fld_wdata & SW_VALID;
        end
      end
      FID_SNS_MASK: begin
        rd_value = sensor_condition_enable_mask;
        if (wr_en) begin
          next_sns_mask = fld_wdata & SNS_VALID;
        end
      end
      default: begin
        id_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hw_condition_enable_mask <= HW_MASK_RST;
      link_condition_enable_mask <= LINK_MASK_RST;
      sw_condition_enable_mask <= SW_MASK_RST;
      sensor_condition_enable_mask <= SNS_MASK_RST;
    end else if (ce) begin
      hw_condition_enable_mask <= next_hw_mask;
      link_condition_enable_mask <= next_link_mask;
      sw_condition_enable_mask <= next_sw_mask;
      sensor_condition_enable_mask <= next_sns_mask;
    end
  end

  // Write answers with the value now stored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fld_rsp_valid <= 1'b0;
      fld_rsp_error <= 1'b0;
      fld_rsp_data <= FIELD_RST;
    end else if (ce) begin
      fld_rsp_valid <= fld_cmd_valid;
      fld_rsp_error <= fld_cmd_valid && !id_hit;
      if (fld_cmd_valid) begin
        fld_rsp_data <= FIELD_RST;
        unique case (fld_id)
          FID_HW_MASK: fld_rsp_data <= next_hw_mask;
          FID_LINK_MASK: fld_rsp_data <= next_link_mask;
          FID_SW_MASK: fld_rsp_data <= next_sw_mask;
          FID_SNS_MASK: fld_rsp_data <= next_sns_mask;
          default: fld_rsp_data <= FIELD_RST;
        endcase
        if (!fld_cmd_write) begin
          fld_rsp_data <= rd_value;
        end
      end
    end
  end

  // ************************************************
  // Master word
  // ************************************************

  // Built from next values so it moves with fields
  always_comb begin
    hw_sum = |(next_hw & next_hw_mask);
    link_sum = |(next_link & next_link_mask);
    sw_sum = |(next_sw & next_sw_mask);
    sns_sum = |(next_sns & next_sns_mask);
    next_word = FIELD_RST;
    // All errors here are hard: no persistence
    next_word[MW_FATAL_BIT] = |next_grp;
    next_word[MW_SWERR_BIT] = |next_grp;
    next_word[MW_ALERT_BIT] = hw_sum | link_sum | sw_sum | sns_sum;
    next_word[MW_HW_BIT] = hw_sum;
    next_word[MW_LINK_BIT] = link_sum;
    next_word[MW_SW_BIT] = sw_sum;
    next_word[MW_SNS_BIT] = sns_sum;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      health_master_word <= FIELD_RST;
    end else if (ce) begin
      health_master_word <= next_word;
    end
  end

  // ************************************************
  // Checks
  // ************************************************

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_wr(logic [FW-1:0] id);
    ce && fld_cmd_valid && fld_cmd_write && fld_id == id;
  endsequence

  sequence s_rsp_ok;
    fld_rsp_valid && !fld_rsp_error;
  endsequence

  chk_alg_or: assert property (
    sw_error_group[GRP_ALG_BIT] == |algorithm_error_detail)
    else $error("algorithm summary mismatch");

  chk_init_sticky: assert property (
    ce && init_error |=> algorithm_error_detail[ALG_INIT_BIT] [*4])
    else $error("init error bit not held");

  chk_range_bit: assert property (
    ce && range_fatal |=> algorithm_error_detail[ALG_RANGE_BIT]
    && (algorithm_error_detail & ~ALG_VALID) == FIELD_RST)
    else $error("range fatal bit wrong");

  chk_data_or: assert property (
    sw_error_group[GRP_DATA_BIT] == |data_error_detail)
    else $error("data summary mismatch");

  chk_calib_bit: assert property (
    ce && calib_checksum_fault |=> data_error_detail[DATA_CALIB_BIT])
    else $error("checksum fault not flagged");

  chk_hw_summary: assert property (
    health_master_word[MW_HW_BIT]
    == |(hw_condition & hw_condition_enable_mask))
    else $error("hardware summary mismatch");

  chk_unlock_follow: assert property (
    ce |=> hw_condition == ({15'h0000, $past(calib_write_unlocked)}
    << HW_UNLOCK_BIT))
    else $error("unlock bit does not follow");

  chk_sw_summary: assert property (
    health_master_word[MW_SW_BIT]
    == |(sw_condition & sw_condition_enable_mask))
    else $error("software summary mismatch");

  chk_sw_bits: assert property (
    ce |=> sw_condition[SW_INIT_BIT] == $past(filter_initializing)
    && sw_condition[SW_ORIENT_BIT] == $past(orientation_only_tracking)
    && sw_condition[SW_TURN_BIT] == $past(turn_rate_exceeded)
    && (sw_condition & ~SW_VALID) == FIELD_RST)
    else $error("software condition bits wrong");

  chk_sns_summary: assert property (
    health_master_word[MW_SNS_BIT]
    == (sensor_condition[SNS_RANGE_BIT]
    && sensor_condition_enable_mask[SNS_RANGE_BIT]))
    else $error("sensor summary mismatch");

  chk_hw_write: assert property (
    s_wr(FID_HW_MASK) |=> s_rsp_ok ##0
    hw_condition_enable_mask == ($past(fld_wdata) & HW_VALID))
    else $error("hardware mask write lost");

  chk_sns_write: assert property (
    s_wr(FID_SNS_MASK) |=> s_rsp_ok ##0
    sensor_condition_enable_mask == ($past(fld_wdata) & SNS_VALID)
    && fld_rsp_data == sensor_condition_enable_mask)
    else $error("sensor mask write lost");

  chk_bad_id: assert property (
    ce && fld_cmd_valid && !id_hit |=> fld_rsp_valid && fld_rsp_error)
    else $error("unknown field not refused");

  chk_link_alert: assert property (
    health_master_word[MW_LINK_BIT]
    == |(link_field & link_condition_enable_mask)
    && (!health_master_word[MW_LINK_BIT]
    || health_master_word[MW_ALERT_BIT]))
    else $error("link alert mismatch");

  chk_master_or: assert property (
    health_master_word[MW_ALERT_BIT]
    == |health_master_word[MW_SNS_BIT:MW_HW_BIT])
    else $error("top alert mismatch");

  chk_fatal_now: assert property (
    ce && (init_error || calib_checksum_fault)
    |=> health_master_word[MW_FATAL_BIT]
    && health_master_word[MW_SWERR_BIT])
    else $error("top fatal late");

endmodule

// file: dv/test_bit_status_flag_aggregator.sv
// Self-checking bench for the status flag aggregator
`timescale 1ns/1ps
module test_bit_status_flag_aggregator;
  import bsfa_pkg::*;
  logic clk_sys, rstn, ce;
  logic init_error, range_fatal, calib_checksum_fault;
  logic calib_write_unlocked, filter_initializing;
  logic orientation_only_tracking, turn_rate_exceeded, range_excursion;
  logic [FW-1:0] link_condition, fld_id, fld_wdata, fld_rsp_data;
  logic fld_cmd_valid, fld_cmd_write, fld_rsp_valid, fld_rsp_error;
  logic [FW-1:0] alg, dat, grp, hwc, swc, snc, mw;
  int mismatches, num_checks;
  // Rows: hw, link, sw, sensor masks, conditions, link field, master word
  // Conditions: 4 unlocked, 3 init, 2 orientation, 1 turn, 0 range
  logic [15:0] tbl [11][7] = '{
    '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0008, 16'h0000, 16'h0900},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h001f, 16'hffff, 16'h0000},
    '{16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0000, 16'h0300},
    '{16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0004, 16'h0500},
    '{16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h000f, 16'hfffb, 16'h0000},
    '{16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h0004, 16'h0000, 16'h0900},
    '{16'h0000, 16'h0000, 16'h0008, 16'h0000, 16'h000a, 16'h0000, 16'h0900},
    '{16'h0000, 16'h0000, 16'hfff2, 16'h0000, 16'h000f, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h1100},
    '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h001f, 16'h8000, 16'h1f00}};

  bsfa_core dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce),
    .init_error(init_error), .range_fatal(range_fatal),
    .calib_checksum_fault(calib_checksum_fault),
    .calib_write_unlocked(calib_write_unlocked),
    .filter_initializing(filter_initializing),
    .orientation_only_tracking(orientation_only_tracking),
    .turn_rate_exceeded(turn_rate_exceeded),
    .range_excursion(range_excursion), .link_condition(link_condition),
    .fld_cmd_valid(fld_cmd_valid), .fld_cmd_write(fld_cmd_write),
    .fld_id(fld_id), .fld_wdata(fld_wdata),
    .fld_rsp_valid(fld_rsp_valid), .fld_rsp_error(fld_rsp_error),
    .fld_rsp_data(fld_rsp_data), .algorithm_error_detail(alg),
    .data_error_detail(dat), .sw_error_group(grp), .hw_condition(hwc),
    .sw_condition(swc), .sensor_condition(snc), .health_master_word(mw));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [FW-1:0] exp,
                     input logic [FW-1:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // One field command, answered one cycle later; valid left high
  task automatic cmd(input logic wr, input logic [FW-1:0] id,
                     input logic [FW-1:0] wd, input logic err,
                     input logic [FW-1:0] exp);
    fld_cmd_valid = 1'b1;
    fld_cmd_write = wr;
    fld_id = id;
    fld_wdata = wd;
    step();
    chk("rsp_valid", 16'h0001, {15'h0, fld_rsp_valid});
    chk("rsp_error", {15'h0, err}, {15'h0, fld_rsp_error});
    chk("rsp_data", exp, fld_rsp_data);
  endtask

  task automatic setc(input logic [15:0] c, input logic [15:0] lk);
    calib_write_unlocked = c[4];
    filter_initializing = c[3];
    orientation_only_tracking = c[2];
    turn_rate_exceeded = c[1];
    range_excursion = c[0];
    link_condition = lk;
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    init_error = 1'b0;
    range_fatal = 1'b0;
    calib_checksum_fault = 1'b0;
    fld_cmd_valid = 1'b0;
    fld_cmd_write = 1'b0;
    fld_id = 16'h0000;
    fld_wdata = 16'h0000;
    setc(16'h0000, 16'h0000);
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    for (int r = 0; r < 11; r++) begin
      setc(tbl[r][4], tbl[r][5]);
      cmd(1'b1, FID_HW_MASK, tbl[r][0], 1'b0,
          tbl[r][0] & HW_VALID);
      cmd(1'b1, FID_LINK_MASK, tbl[r][1], 1'b0,
          tbl[r][1]);
      cmd(1'b1, FID_SW_MASK, tbl[r][2], 1'b0,
          tbl[r][2] & SW_VALID);
      cmd(1'b1, FID_SNS_MASK, tbl[r][3], 1'b0,
          tbl[r][3] & SNS_VALID);
      chk("hw_condition", {12'h0, tbl[r][4][4], 3'h0}, hwc);
      chk("sw_condition", {12'h0, tbl[r][4][1], tbl[r][4][2], 1'b0,
          tbl[r][4][3]}, swc);
      chk("sensor_condition", {15'h0, tbl[r][4][0]}, snc);
      chk("master_word", tbl[r][6],
          mw);
    end
    // Hard errors, sticky after the source drops
    fld_cmd_valid = 1'b0;
    setc(16'h0000, 16'h0000);
    init_error = 1'b1;
    step();
    init_error = 1'b0;
    chk("master_word", 16'h0009, mw);
    step();
    chk("alg_detail", 16'h0001, alg);
    chk("err_group", 16'h0001, grp);
    range_fatal = 1'b1;
    step();
    range_fatal = 1'b0;
    chk("alg_detail", 16'h0003, alg);
    calib_checksum_fault = 1'b1;
    step();
    calib_checksum_fault = 1'b0;
    step();
    chk("data_detail", 16'h0001, dat);
    chk("err_group", 16'h0003, grp);
    chk("master_word", 16'h0009, mw);
    // Unknown identifiers refused without side effects
    cmd(1'b0, 16'h0014, 16'h0000, 1'b1, 16'h0000);
    cmd(1'b1, 16'h000f, 16'h0000, 1'b1, 16'h0000);
    cmd(1'b0, FID_SW_MASK, 16'h0000, 1'b0, 16'h000d);
    fld_cmd_valid = 1'b0;
    step();
    chk("rsp_idle", 16'h0000, {15'h0, fld_rsp_valid});
    // Frozen while the enable is low
    ce = 1'b0;
    range_excursion = 1'b1;
    fld_cmd_valid = 1'b1;
    step();
    chk("rsp_valid", 16'h0000, {15'h0, fld_rsp_valid});
    chk("sensor_condition", 16'h0000, snc);
    chk("master_word", 16'h0009, mw);
    ce = 1'b1;
    fld_cmd_valid = 1'b0;
    step();
    chk("master_word", 16'h1109, mw);
    // Back-to-back write then read
    fld_cmd_valid = 1'b1;
    fld_cmd_write = 1'b1;
    fld_id = FID_LINK_MASK;
    fld_wdata = 16'h1234;
    step();
    fld_cmd_write = 1'b0;
    chk("b2b_write", 16'h1234, fld_rsp_data);
    step();
    fld_cmd_valid = 1'b0;
    chk("b2b_valid", 16'h0001, {15'h0, fld_rsp_valid});
    chk("b2b_read", 16'h1234, fld_rsp_data);
    // Second reset clears errors and restores masks
    rstn = 1'b0;
    step();
    chk("alg_detail", 16'h0000, alg);
    rstn = 1'b1;
    setc(16'h0000, 16'h0000);
    cmd(1'b0, FID_HW_MASK, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b0, FID_LINK_MASK, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b0, FID_SW_MASK, 16'h0000, 1'b0, 16'h0001);
    cmd(1'b0, FID_SNS_MASK, 16'h0000, 1'b0, 16'h0001);
    chk("master_word", 16'h0000, mw);
    end_of_test();
  end
endmodule

// file: include/bsfa_pkg.sv
// Constants for the status flag aggregator
package bsfa_pkg;
  localparam int FW = 16;
  // Field identifiers served by the field command port
  localparam logic [15:0] FID_HW_MASK = 16'h0010;
  localparam logic [15:0] FID_LINK_MASK = 16'h0011;
  localparam logic [15:0] FID_SW_MASK = 16'h0012;
  localparam logic [15:0] FID_SNS_MASK = 16'h0013;
  // Bit positions inside the detail and condition fields
  localparam int ALG_INIT_BIT = 0;
  localparam int ALG_RANGE_BIT = 1;
  localparam int DATA_CALIB_BIT = 0;
  localparam int HW_UNLOCK_BIT = 3;
  localparam int SW_INIT_BIT = 0;
  localparam int SW_ORIENT_BIT = 2;
  localparam int SW_TURN_BIT = 3;
  localparam int SNS_RANGE_BIT = 0;
  // Bit positions inside the error group
  localparam int GRP_ALG_BIT = 0;
  localparam int GRP_DATA_BIT = 1;
  // Bit positions inside the master word
  localparam int MW_FATAL_BIT = 0;
  localparam int MW_SWERR_BIT = 3;
  localparam int MW_ALERT_BIT = 8;
  localparam int MW_HW_BIT = 9;
  localparam int MW_LINK_BIT = 10;
  localparam int MW_SW_BIT = 11;
  localparam int MW_SNS_BIT = 12;
  // Defined (non-reserved) bits of each field
  localparam logic [15:0] ALG_VALID = 16'h0003;
  localparam logic [15:0] DATA_VALID = 16'h0001;
  localparam logic [15:0] GRP_VALID = 16'h0003;
  localparam logic [15:0] HW_VALID = 16'h0008;
  localparam logic [15:0] SW_VALID = 16'h000d;
  localparam logic [15:0] SNS_VALID = 16'h0001;
  localparam logic [15:0] LINK_VALID = 16'hffff;
  // Reset values
  localparam logic [15:0] FIELD_RST = 16'h0000;
  localparam logic [15:0] HW_MASK_RST = 16'h0000;
  localparam logic [15:0] LINK_MASK_RST = 16'h0000;
  localparam logic [15:0] SW_MASK_RST = 16'h0001;
  localparam logic [15:0] SNS_MASK_RST = 16'h0001;
endpackage
